//--- supply_match_and_power_event_status.sv
// Function
// RL1 - result bit is one when sensed supply exceeds its programmed threshold
// RL2 - result bits 5:2 thresholds 3..0, bit 0 safe-zero; 7:6,1 reserved
// RL3 - outside standalone, results read zero until comparator is enabled
// RL4 - selected thresholds pass the debouncer; others use raw result
// RL5 - change flag sets whenever its result bit changes, stays set
// RL6 - writing one clears a change flag, writing zero leaves it
// RL7 - power bit 7 sets when results first become valid after enable
// RL8 - power bit 6: cable power stays high too long while draining
// RL9 - power bit 5 follows back-drive on second CC pin, level source
// RL10 - power bit 1 follows back-drive on first CC pin, level source
// RL11 - power bit 4 latches supply drain overrun pulse until cleared
// RL12 - power bits 3,2 show second and first cable FET supplying power
// RL13 - power bit 0 shows cable FET over-current, level source
// RL14 - level-sourced flags reassert after clear while condition lasts
// RL15 - pulse-sourced flags latch and hold until cleared, never reassert
// RL16 - diagnostic bit 3 shows cable power draining, standalone DFP only
// RL17 - diagnostic bit 2 shows supply draining, level until finished
// RL18 - diagnostic bits 1,0 latch strap sampling done after a request
// RL19 - diagnostic bits 7:4 reserved, read zero
// RL20 - change flag raises supply interrupt only when its mask bit is set
// RL21 - reserved bits in all four registers read zero, ignore writes
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module supply_match_and_power_event_status
	import supply_status_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES    = SUPPLY_DEBOUNCE_CYCLES,
	parameter int DRAIN_LIMIT_CYCLES = CABLE_DRAIN_LIMIT_CYCLES,
	parameter int DEB_W              = 16,
	parameter int DRAIN_W            = 24
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic              hresp,
	output logic [31:0]       hrdata,
	input  wire supply_hits_t supply_level_raw,
	input  wire power_cond_t  cond,
	output supply_ctrl_t      ctrl,
	output logic              supply_irq
);

	// bus address phase capture
	logic        wr_pend;
	logic [11:0] wr_idx;
	logic        take;
	logic [11:0] a_idx;

	// no wait states: every register answers from flops or a mux
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign take      = hsel && hready && htrans[1];
	assign a_idx     = haddr[13:2];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_idx  <= 12'h000;
		end else begin
			wr_pend <= take && hwrite && (hsize == 3'h2);
			wr_idx  <= a_idx;
		end
	end

	// data-phase write strobes
	logic       wr_change;
	logic       wr_power;
	logic       wr_diag;
	logic       wr_mask;
	logic       wr_ctrl;
	logic       wr_dbsel;
	logic [7:0] wbyte;

	assign wbyte     = hwdata[7:0];
	assign wr_change = wr_pend && (wr_idx == IDX_SUPPLY_CHANGE);
	assign wr_power  = wr_pend && (wr_idx == IDX_POWER_EVENTS);
	assign wr_diag   = wr_pend && (wr_idx == IDX_DIAG_EVENTS);
	assign wr_mask   = wr_pend && (wr_idx == IDX_SUPPLY_IRQ_MASK);
	assign wr_ctrl   = wr_pend && (wr_idx == IDX_SUPPLY_CONTROL);
	assign wr_dbsel  = wr_pend && (wr_idx == IDX_DEBOUNCE_SELECT);

	// software-owned settings
	logic [7:0] ctrl_reg;
	logic [7:0] debounce_select;
	logic [7:0] irq_mask;
	logic       strap_a_evt;
	logic       strap_b_evt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			debounce_select <= RESET_BYTE;
			irq_mask        <= RESET_BYTE;
		end else begin
			if (wr_dbsel)
				debounce_select <= wbyte & SUPPLY_IMPL_MASK;
			if (wr_mask)
				irq_mask <= wbyte & SUPPLY_IMPL_MASK; // RL21
		end
	end

	// sample requests drop when the sampler reports done
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg <= RESET_BYTE;
		end else if (wr_ctrl) begin
			ctrl_reg <= wbyte & CONTROL_MASK;
		end else begin
			if (strap_a_evt)
				ctrl_reg[CTL_STRAP_A_REQ] <= 1'b0;
			if (strap_b_evt)
				ctrl_reg[CTL_STRAP_B_REQ] <= 1'b0;
		end
	end

	assign ctrl.comp_enable         = ctrl_reg[CTL_COMP_ENABLE];
	assign ctrl.standalone          = ctrl_reg[CTL_STANDALONE];
	assign ctrl.dfp                 = ctrl_reg[CTL_DFP];
	assign ctrl.strap_sample_req[0] = ctrl_reg[CTL_STRAP_A_REQ];
	assign ctrl.strap_sample_req[1] = ctrl_reg[CTL_STRAP_B_REQ];
	assign ctrl.cable_drain_ctrl    = ctrl_reg[CTL_DRAIN_LO +: 2];

	logic comp_en;
	logic standalone_dfp;

	assign comp_en        = ctrl_reg[CTL_COMP_ENABLE];
	assign standalone_dfp = ctrl_reg[CTL_STANDALONE] && ctrl_reg[CTL_DFP];

	// comparator outputs are asynchronous to hclk
	// bits are synchronised one by one; skew between them is absorbed
	// by the debouncer or shows as two quick changes when unselected
	logic [7:0] raw_map;
	logic [7:0] raw_meta;
	logic [7:0] raw_sync;

	assign raw_map = {2'b00, supply_level_raw.level3,
		supply_level_raw.level2, supply_level_raw.level1,
		supply_level_raw.level0, 1'b0, supply_level_raw.safe_zero}; // RL2

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			raw_meta <= RESET_BYTE;
			raw_sync <= RESET_BYTE;
		end else begin
			raw_meta <= raw_map;
			raw_sync <= raw_meta;
		end
	end

	// per-threshold debouncer
	logic [7:0] filt;
	logic [7:0] settled;

	localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEBOUNCE_CYCLES - 1);

	for (genvar i = 0; i < 8; i++) begin : g_deb
		if (SUPPLY_IMPL_MASK[i]) begin : g_on
			logic [DEB_W-1:0] cnt;
			logic             last;
			logic             f;
			logic             s;

			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					cnt  <= '0;
					last <= 1'b0;
					f    <= 1'b0;
					s    <= 1'b0;
				end else begin
					last <= raw_sync[i];
					if (!comp_en) begin
						cnt <= '0;
						s   <= 1'b0;
					end else if (!debounce_select[i]) begin
						cnt <= '0;
						f   <= raw_sync[i]; // RL4
						s   <= 1'b1;
					end else if (raw_sync[i] != last) begin
						cnt <= '0;
					end else if (cnt == DEB_LAST) begin
						f   <= raw_sync[i]; // RL4
						s   <= 1'b1;
					end else begin
						cnt <= cnt + 1'b1;
					end
				end
			end
			assign filt[i]    = f;
			assign settled[i] = s;
		end else begin : g_off
			assign filt[i]    = 1'b0;
			assign settled[i] = 1'b1;
		end
	end

	// visible results: zero until enabled unless standalone
	// limitation: standalone with the comparator off shows held results
	logic [7:0] results;
	logic [7:0] results_prev;

	assign results = (comp_en || ctrl_reg[CTL_STANDALONE]) ?
		(filt & SUPPLY_IMPL_MASK) : RESET_BYTE; // RL1 RL3

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			results_prev <= RESET_BYTE;
		else
			results_prev <= results;
	end

	// change flags, set beats a same-cycle clear
	// so a change landing with a clear write is never lost
	logic [7:0] change_flags;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			change_flags <= RESET_BYTE;
		else
			change_flags <= (change_flags & ~(wr_change ? wbyte : 8'h00))
				| (results ^ results_prev); // RL5 RL6
	end

	assign supply_irq = |(change_flags & irq_mask); // RL20

	// first valid result after the comparator is enabled
	logic valid_lvl;
	logic valid_seen;
	logic valid_evt;

	assign valid_lvl = comp_en && (&settled);
	assign valid_evt = valid_lvl && !valid_seen;

	// only the first enable counts; re-enabling does not re-raise it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			valid_seen <= 1'b0;
		else if (valid_lvl)
			valid_seen <= 1'b1; // RL7
	end

	// cable power drain watchdog
	logic [DRAIN_W-1:0] drain_cnt;
	logic               drain_watch;
	logic               cable_fault_evt;

	localparam logic [DRAIN_W-1:0] DRAIN_LIMIT = DRAIN_W'(DRAIN_LIMIT_CYCLES);

	assign drain_watch = standalone_dfp && !ctrl_reg[CTL_DRAIN_LO + 1]
		&& cond.cable_power_draining && cond.cable_power_above_level; // RL8
	assign cable_fault_evt = drain_watch && (drain_cnt == DRAIN_LIMIT); // RL8

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			drain_cnt <= '0;
		else if (!drain_watch)
			drain_cnt <= '0;
		else if (drain_cnt <= DRAIN_LIMIT)
			drain_cnt <= drain_cnt + 1'b1;
	end

	// power event flags
	// level sources set again every cycle, so a clear only sticks once
	// the condition has gone; pulse sources hold until software clears
	logic [7:0] power_flags;
	logic [7:0] power_set;

	always_comb begin
		power_set                    = 8'h00;
		power_set[PWR_RESULTS_VALID] = valid_evt; // RL7
		power_set[PWR_CABLE_FAULT]   = cable_fault_evt; // RL8
		power_set[PWR_CC2_BACKDRIVE] = cond.cc2_backdrive; // RL9 RL14
		power_set[PWR_SUPPLY_FAULT]  = cond.supply_drain_fault; // RL11 RL15
		power_set[PWR_FET2_ON]       = cond.fet2_on; // RL12 RL14
		power_set[PWR_FET1_ON]       = cond.fet1_on; // RL12 RL14
		power_set[PWR_CC1_BACKDRIVE] = cond.cc1_backdrive; // RL10 RL14
		power_set[PWR_OVERCURRENT]   = cond.vconn_overcurrent; // RL13 RL14
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			power_flags <= RESET_BYTE;
		else
			power_flags <= (power_flags & ~(wr_power ? wbyte : 8'h00))
				| power_set;
	end

	// diagnostic flags; done pulses count only while requested
	logic [7:0] diag_flags;
	logic [7:0] diag_set;

	assign strap_a_evt = cond.strap_a_done && ctrl_reg[CTL_STRAP_A_REQ];
	assign strap_b_evt = cond.strap_b_done && ctrl_reg[CTL_STRAP_B_REQ];

	always_comb begin
		diag_set                      = 8'h00;
		diag_set[DBG_CABLE_DRAINING]  = standalone_dfp
			&& cond.cable_power_draining; // RL16
		diag_set[DBG_SUPPLY_DRAINING] = cond.supply_draining; // RL17
		diag_set[DBG_STRAP_B_DONE]    = strap_b_evt; // RL18
		diag_set[DBG_STRAP_A_DONE]    = strap_a_evt; // RL18
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			diag_flags <= RESET_BYTE;
		else
			diag_flags <= ((diag_flags & ~(wr_diag ? wbyte : 8'h00))
				| diag_set) & DIAG_IMPL_MASK; // RL19
	end

	// read side; reserved positions forced low
	logic [7:0] rd_byte;

	always_comb begin
		case (a_idx)
			IDX_SUPPLY_RESULTS:  rd_byte = results;
			IDX_SUPPLY_CHANGE:   rd_byte = change_flags & SUPPLY_IMPL_MASK;
			IDX_POWER_EVENTS: begin
				rd_byte = power_flags;
				if (!standalone_dfp)
					rd_byte[PWR_CABLE_FAULT] = 1'b0; // RL8
			end
			IDX_DIAG_EVENTS: begin
				rd_byte = diag_flags; // RL19
				if (!standalone_dfp)
					rd_byte[DBG_CABLE_DRAINING] = 1'b0; // RL16
			end
			IDX_SUPPLY_IRQ_MASK: rd_byte = irq_mask;
			IDX_SUPPLY_CONTROL:  rd_byte = ctrl_reg;
			IDX_DEBOUNCE_SELECT: rd_byte = debounce_select;
			default:             rd_byte = 8'h00;
		endcase
	end

	// per-register mask of implemented positions; reserved reads zero
	logic [7:0] rd_keep;
	logic [7:0] power_keep;
	logic [7:0] diag_keep;

	// mode-only bits vanish from reads outside standalone DFP
	always_comb begin
		power_keep                    = 8'hff;
		power_keep[PWR_CABLE_FAULT]   = standalone_dfp; // RL8
		diag_keep                     = DIAG_IMPL_MASK;
		diag_keep[DBG_CABLE_DRAINING] = standalone_dfp; // RL16
	end

	always_comb begin
		case (a_idx)
			IDX_SUPPLY_RESULTS:  rd_keep = SUPPLY_IMPL_MASK; // RL2
			IDX_SUPPLY_CHANGE:   rd_keep = SUPPLY_IMPL_MASK; // RL21
			IDX_POWER_EVENTS:    rd_keep = power_keep;
			IDX_DIAG_EVENTS:     rd_keep = diag_keep; // RL19
			IDX_SUPPLY_IRQ_MASK: rd_keep = SUPPLY_IMPL_MASK; // RL21
			IDX_SUPPLY_CONTROL:  rd_keep = CONTROL_MASK;
			IDX_DEBOUNCE_SELECT: rd_keep = SUPPLY_IMPL_MASK;
			default:             rd_keep = 8'h00;
		endcase
	end

	// read data registered at the address phase for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (take && !hwrite)
			hrdata <= {24'h00_0000, rd_byte & rd_keep};
	end

endmodule

//--- supply_match_and_power_event_status_tb.sv
`timescale 1ns/1ps
module supply_match_and_power_event_status_tb;
	import supply_status_pkg::*;
	logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp, supply_irq;
	logic [31:0]  haddr, hwdata, hrdata;
	logic [1:0]   htrans;
	logic [2:0]   hsize;
	logic         rd_dp;
	supply_hits_t raw;
	power_cond_t  cond;
	supply_ctrl_t ctrl;
	logic [31:0]  exp_q[$], msk_q[$];
	int           fails, checked, seed;
	localparam logic [11:0] REGS [6] = '{IDX_SUPPLY_RESULTS, IDX_SUPPLY_CHANGE,
		IDX_POWER_EVENTS, IDX_DIAG_EVENTS, IDX_SUPPLY_IRQ_MASK, 12'h900};

	supply_match_and_power_event_status #(.DEBOUNCE_CYCLES(4),
		.DRAIN_LIMIT_CYCLES(8)) supply_match_and_power_event_status_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .supply_level_raw(raw), .cond(cond), .ctrl(ctrl),
		.supply_irq(supply_irq));

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	task automatic chk(string what, logic [31:0] seen, logic [31:0] want);
		checked++;
		if (seen !== want) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// read data stands one cycle after the address is taken
	always @(posedge hclk) begin
		if (rd_dp) begin
			chk("hrdata", hrdata & msk_q.pop_front(), exp_q.pop_front());
			chk("hresp", {31'h0, hresp}, 32'h0);
		end
		rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
	end

	task automatic xfer(logic w, logic [11:0] idx, logic [7:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr  <= {18'h0, idx, 2'b00};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
	endtask

	task automatic wr(logic [11:0] idx, logic [7:0] d);
		xfer(1'b1, idx, d);
	endtask

	task automatic rd(logic [11:0] idx, logic [7:0] e, logic [7:0] m);
		exp_q.push_back({24'h0, e & m});
		msk_q.push_back({24'hffffff, m});
		xfer(1'b0, idx, 8'h00);
	endtask

	task automatic irq_is(logic e);
		#1;
		chk("supply_irq", {31'h0, supply_irq}, {31'h0, e});
	endtask

	task automatic pulse(logic [10:0] p);
		cond <= power_cond_t'(p);
		@(posedge hclk);
		cond <= '0;
	endtask

	function automatic logic [7:0] vis(supply_hits_t r);
		return {2'b00, r[4:1], 1'b0, r[0]};
	endfunction

	initial begin
		logic [7:0]   ch, prev;
		supply_hits_t b;
		seed = 32'h3e3a;
		{hresetn, hsel, hwrite} = '0;
		{haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		raw = '1;
		cond = '0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			rd(REGS[i], 8'h00, 8'hff);
		wr(IDX_SUPPLY_IRQ_MASK, 8'hff);
		rd(IDX_SUPPLY_IRQ_MASK, 8'h3d, 8'hff);
		wr(IDX_SUPPLY_RESULTS, 8'hff);
		wr(IDX_DIAG_EVENTS, 8'hff);
		rd(IDX_SUPPLY_RESULTS, 8'h00, 8'hff);
		rd(IDX_DIAG_EVENTS, 8'h00, 8'hff);
		wr(IDX_SUPPLY_CONTROL, 8'h01);
		repeat (12) @(posedge hclk);
		irq_is(1'b1);
		rd(IDX_SUPPLY_RESULTS, 8'h3d, 8'hff);
		rd(IDX_POWER_EVENTS, 8'h80, 8'h80);
		wr(IDX_SUPPLY_IRQ_MASK, 8'h00);
		irq_is(1'b0);
		wr(IDX_SUPPLY_CHANGE, 8'h00);
		rd(IDX_SUPPLY_CHANGE, 8'h3d, 8'hff);
		wr(IDX_SUPPLY_CHANGE, 8'hff);
		ch = 8'h00;
		for (int i = 0; i < 6; i++) begin
			prev = vis(raw);
			raw <= supply_hits_t'($random(seed));
			repeat (12) @(posedge hclk);
			ch |= prev ^ vis(raw);
			rd(IDX_SUPPLY_RESULTS, vis(raw), 8'hff);
		end
		rd(IDX_SUPPLY_CHANGE, ch, 8'hff);
		wr(IDX_SUPPLY_IRQ_MASK, 8'h3d);
		irq_is(|ch);
		wr(IDX_SUPPLY_CHANGE, 8'hff);
		irq_is(1'b0);
		// short glitch: filtered when selected, passed through when not
		b = raw;
		for (int s = 0; s < 2; s++) begin
			wr(IDX_DEBOUNCE_SELECT, s ? 8'h00 : 8'h3d);
			raw <= ~b;
			repeat (2) @(posedge hclk);
			raw <= b;
			repeat (12) @(posedge hclk);
			rd(IDX_SUPPLY_CHANGE, s ? 8'h3d : 8'h00, 8'hff);
			wr(IDX_SUPPLY_CHANGE, 8'hff);
		end
		cond <= power_cond_t'(11'h7c4);
		repeat (4) @(posedge hclk);
		wr(IDX_POWER_EVENTS, 8'hff);
		wr(IDX_DIAG_EVENTS, 8'hff);
		rd(IDX_POWER_EVENTS, 8'h2f, 8'h7f);
		rd(IDX_DIAG_EVENTS, 8'h04, 8'hff);
		cond <= '0;
		repeat (3) @(posedge hclk);
		wr(IDX_POWER_EVENTS, 8'hff);
		wr(IDX_DIAG_EVENTS, 8'hff);
		rd(IDX_POWER_EVENTS, 8'h00, 8'hff);
		pulse(11'h020);
		rd(IDX_POWER_EVENTS, 8'h10, 8'h10);
		rd(IDX_POWER_EVENTS, 8'h10, 8'h10);
		wr(IDX_POWER_EVENTS, 8'hff);
		rd(IDX_POWER_EVENTS, 8'h00, 8'h10);
		pulse(11'h003);
		rd(IDX_DIAG_EVENTS, 8'h00, 8'h03);
		wr(IDX_SUPPLY_CONTROL, 8'h31);
		#1;
		chk("ctrl", {25'h0, ctrl}, 32'h4c);
		pulse(11'h003);
		rd(IDX_DIAG_EVENTS, 8'h03, 8'h03);
		rd(IDX_SUPPLY_CONTROL, 8'h01, 8'hff);
		wr(IDX_DIAG_EVENTS, 8'hff);
		rd(IDX_DIAG_EVENTS, 8'h00, 8'hff);
		wr(IDX_SUPPLY_CONTROL, 8'h07);
		cond <= power_cond_t'(11'h018);
		repeat (14) @(posedge hclk);
		rd(IDX_POWER_EVENTS, 8'h40, 8'h40);
		rd(IDX_DIAG_EVENTS, 8'h08, 8'h08);
		wr(IDX_SUPPLY_CONTROL, 8'h87);
		#1;
		chk("ctrl", {25'h0, ctrl}, 32'h72);
		wr(IDX_POWER_EVENTS, 8'hff);
		repeat (14) @(posedge hclk);
		rd(IDX_POWER_EVENTS, 8'h00, 8'h40);
		cond <= '0;
		repeat (2) @(posedge hclk);
		summarize();
	end

	initial begin
		repeat (20000) @(posedge hclk);
		fails++;
		summarize();
	end
endmodule

bind supply_match_and_power_event_status supply_status_properties
	supply_status_properties_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
	.supply_level_raw, .cond, .ctrl, .supply_irq);

//--- supply_status_pkg.sv
package supply_status_pkg;

	// clock
	localparam int CLK_PERIOD_NS = 25;

	// timing figures in their own units, cycle counts derived
	localparam int SUPPLY_DEBOUNCE_US     = 1000;
	localparam int SUPPLY_DEBOUNCE_CYCLES =
		SUPPLY_DEBOUNCE_US * 1000 / CLK_PERIOD_NS;
	localparam int CABLE_DRAIN_LIMIT_US     = 10000;
	localparam int CABLE_DRAIN_LIMIT_CYCLES =
		CABLE_DRAIN_LIMIT_US * 1000 / CLK_PERIOD_NS;

	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_SUPPLY_RESULTS  = 12'h808;
	localparam logic [11:0] IDX_SUPPLY_CHANGE   = 12'h809;
	localparam logic [11:0] IDX_POWER_EVENTS    = 12'h80a;
	localparam logic [11:0] IDX_DIAG_EVENTS     = 12'h80b;
	localparam logic [11:0] IDX_SUPPLY_IRQ_MASK = 12'h814;
	localparam logic [11:0] IDX_SUPPLY_CONTROL  = 12'h820;
	localparam logic [11:0] IDX_DEBOUNCE_SELECT = 12'h821;

	// implemented bits
	localparam logic [7:0] SUPPLY_IMPL_MASK = 8'h3d;
	localparam logic [7:0] DIAG_IMPL_MASK   = 8'h0f;
	localparam logic [7:0] CONTROL_MASK     = 8'hf7;

	// power_event_flags positions
	localparam int PWR_RESULTS_VALID = 7;
	localparam int PWR_CABLE_FAULT   = 6;
	localparam int PWR_CC2_BACKDRIVE = 5;
	localparam int PWR_SUPPLY_FAULT  = 4;
	localparam int PWR_FET2_ON       = 3;
	localparam int PWR_FET1_ON       = 2;
	localparam int PWR_CC1_BACKDRIVE = 1;
	localparam int PWR_OVERCURRENT   = 0;

	// diagnostic_event_flags positions
	localparam int DBG_CABLE_DRAINING = 3;
	localparam int DBG_SUPPLY_DRAINING = 2;
	localparam int DBG_STRAP_B_DONE    = 1;
	localparam int DBG_STRAP_A_DONE    = 0;

	// supply control register positions
	localparam int CTL_COMP_ENABLE = 0;
	localparam int CTL_STANDALONE  = 1;
	localparam int CTL_DFP         = 2;
	localparam int CTL_STRAP_A_REQ = 4;
	localparam int CTL_STRAP_B_REQ = 5;
	localparam int CTL_DRAIN_LO    = 6;

	localparam logic [7:0] RESET_BYTE = 8'h00;

	typedef struct packed {
		logic level3;
		logic level2;
		logic level1;
		logic level0;
		logic safe_zero;
	} supply_hits_t;

	typedef struct packed {
		logic vconn_overcurrent;
		logic cc1_backdrive;
		logic cc2_backdrive;
		logic fet1_on;
		logic fet2_on;
		logic supply_drain_fault;
		logic cable_power_above_level;
		logic cable_power_draining;
		logic supply_draining;
		logic strap_a_done;
		logic strap_b_done;
	} power_cond_t;

	typedef struct packed {
		logic       comp_enable;
		logic       standalone;
		logic       dfp;
		logic [1:0] strap_sample_req;
		logic [1:0] cable_drain_ctrl;
	} supply_ctrl_t;

endpackage

//--- supply_status_properties.sv
`timescale 1ns/1ps
module supply_status_properties
	import supply_status_pkg::*;
(
	input wire logic         hclk,
	input wire logic         hresetn,
	input wire logic         hsel,
	input wire logic [31:0]  haddr,
	input wire logic [1:0]   htrans,
	input wire logic         hwrite,
	input wire logic [2:0]   hsize,
	input wire logic [31:0]  hwdata,
	input wire logic         hready,
	input wire logic         hreadyout,
	input wire logic         hresp,
	input wire logic [31:0]  hrdata,
	input wire supply_hits_t supply_level_raw,
	input wire power_cond_t  cond,
	input wire supply_ctrl_t ctrl,
	input wire logic         supply_irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic        take, wr_any, rd_res, rd_pwr, rd_diag, wr_chg;
	logic [11:0] idx;
	logic [8:0]  lv, q1, q2, held;
	logic [3:0]  calm;
	assign idx = haddr[13:2];
	assign take = hsel && hready && htrans[1];
	assign wr_any = take && hwrite;
	assign rd_res = take && !hwrite && idx == IDX_SUPPLY_RESULTS;
	assign rd_pwr = take && !hwrite && idx == IDX_POWER_EVENTS;
	assign rd_diag = take && !hwrite && idx == IDX_DIAG_EVENTS;
	assign wr_chg = wr_any && idx == IDX_SUPPLY_CHANGE;
	assign lv = {cond.supply_draining, 2'b00, cond.cc2_backdrive, 1'b0,
		cond.fet2_on, cond.fet1_on, cond.cc1_backdrive, cond.vconn_overcurrent};
	// three samples high, so either flag latency is accepted
	assign held = lv & q1 & q2;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q1 <= '0;
			q2 <= '0;
		end else begin
			q1 <= lv;
			q2 <= q1;
		end
	end
	// quiet inputs long enough that no change flag can still be pending
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			calm <= '0;
		else if (!$stable(supply_level_raw) || !$stable(ctrl))
			calm <= '0;
		else if (calm != 4'hf)
			calm <= calm + 4'h1;
	end
	a_level_power: assert property (
		rd_pwr |=> (hrdata[5:0] & $past(held[5:0])) == $past(held[5:0]))
		else $error("power level flag missing");
	a_diag_level: assert property (
		rd_diag |=> hrdata[2] || !$past(held[8]))
		else $error("supply draining flag missing");
	a_res_reserved: assert property (
		rd_res |=> (hrdata & ~{24'h0, SUPPLY_IMPL_MASK}) == 32'h0)
		else $error("results reserved bits set");
	a_diag_reserved: assert property (
		rd_diag |=> hrdata[31:4] == 28'h0)
		else $error("diagnostic reserved bits set");
	a_results_off: assert property (
		rd_res && !ctrl.comp_enable && !ctrl.standalone && $stable(ctrl)
		|=> hrdata == 32'h0)
		else $error("results nonzero while comparator off");
	a_pulse_latch: assert property (
		!wr_any && cond.supply_drain_fault ##1 !wr_any ##1 rd_pwr
		|=> hrdata[4])
		else $error("drain fault pulse not latched");
	a_strap_latch: assert property (
		ctrl.strap_sample_req[0] && cond.strap_a_done && !wr_any
		##1 !wr_any ##1 rd_diag |=> hrdata[0])
		else $error("strap a done not latched");
	a_strap_clear: assert property (
		!wr_any ##1 ctrl.strap_sample_req[1] && cond.strap_b_done && !wr_any
		|-> ##2 !ctrl.strap_sample_req[1])
		else $error("strap b request not released");
	a_w1c_clear: assert property (
		wr_chg ##1 hwdata[7:0] == 8'hff && calm == 4'hf |=> !supply_irq)
		else $error("irq stays after clearing all flags");
	a_zero_keeps: assert property (
		wr_chg ##1 hwdata[7:0] == 8'h00 && calm == 4'hf
		|=> $stable(supply_irq))
		else $error("zero write disturbed change flags");
	c_level_read: cover property (rd_pwr && held[0]);
	c_strap_done: cover property (ctrl.strap_sample_req[0] && cond.strap_a_done);
	c_irq_high: cover property (supply_irq);
endmodule
